/* File: gtt_pkg.sv */
/*
 * Shared constants and carrier types of the general timer time-base, followed by the
 * capture/compare channel that the time-base instantiates once per channel.
 * Assumes one clock, a synchronous active-high reset and inputs that are already
 * synchronous to that clock.
 */
package gtt_pkg;
	// ************************************************************
	// Widths and counts
	// ************************************************************
	localparam int GTT_CW = 16;                        // Counter and reload width
	localparam int GTT_NCH = 4;                        // Capture/compare channels
	localparam logic [15:0] GTT_CNT_RST = 16'h0000;    // Counter reset value
	localparam logic [15:0] GTT_PSC_RST = 16'h0000;    // Active prescale reset value
	localparam logic [15:0] GTT_CNT_MAX = 16'hFFFF;    // Encoder underflow reload
	localparam logic [15:0] GTT_ONE = 16'h0001;        // Step of the counters

	// ************************************************************
	// Basic operating modes
	// ************************************************************
	typedef enum logic [1:0] {
		GTT_MODE_TIMER = 2'b00,    // Peripheral clock through the prescaler
		GTT_MODE_COUNT = 2'b01,    // Edges of the selected trigger source
		GTT_MODE_TRIG = 2'b10,     // Timing started by a trigger edge
		GTT_MODE_GATE = 2'b11      // Timing while the external input is active
	} gtt_mode_e;

	// Run state of the time-base
	typedef enum logic [1:0] {
		GTT_ST_STOP = 2'b00,       // Run-enable low, counter and prescaler hold
		GTT_ST_ARMED = 2'b01,      // Waiting for the start trigger
		GTT_ST_RUN = 2'b10         // Counting
	} gtt_state_e;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		gtt_mode_e mode;           // Basic operating mode
		logic trs_sel;             // 1: internal cascade, 0: external input
		logic single_shot;         // 1: single count, 0: continuous
		logic etr_pol;             // 1: external input inverted
		logic toggle_en;           // Toggle output pair enable
		logic enc_en;              // Quadrature encoder counting
	} gtt_ctrl_s;

	typedef struct packed {
		logic capture;             // 1: capture input, 0: compare output
		logic pol;                 // 1: channel input inverted
		logic [15:0] cmp;          // Compare value
	} gtt_chan_cfg_s;
endpackage

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// One capture/compare channel
// ************************************************************
module gtt_chan
	import gtt_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Configuration and stimulus
	input wire gtt_chan_cfg_s cfg_i,
	input wire logic pin_i,
	input wire logic [15:0] count_i,
	input wire logic tick_i,
	// Results
	output logic [15:0] capture_o,
	output logic out_o,
	output logic event_o
);
	logic pin_prev_q;                      // Previous input level after polarity
	logic pin_lvl;                         // Input level after polarity
	logic pin_rise;                        // Active edge of the input

	assign pin_lvl = pin_i ^ cfg_i.pol;
	assign pin_rise = pin_lvl & ~pin_prev_q;

	// Edge detector history, tracks the live level through reset so release makes no false edge
	always_ff @(posedge clk_sys_i) begin
		pin_prev_q <= pin_lvl;
	end

	// Capture latches the count, compare drives a PWM level and flags a match
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			capture_o <= GTT_CNT_RST;
			out_o <= 1'b0;
			event_o <= 1'b0;
		end else if (cfg_i.capture) begin
			// Capture mode
			out_o <= 1'b0;
			event_o <= pin_rise;
			if (pin_rise) begin
				capture_o <= count_i;
			end
		end else begin
			// Compare mode
			out_o <= (count_i < cfg_i.cmp);
			event_o <= tick_i & (count_i == cfg_i.cmp);
		end
	end
endmodule

`default_nettype wire

/* File: gtt_timebase.sv */
/*
 * Time-base of the general timer: prescaler, 16-bit reload counter, run control,
 * trigger and gate handling, encoder counting, toggle pair, event flags and requests.
 * Control bits arrive as plain ports; software-side pulses set or clear run-enable
 * and clear flags. Inputs are synchronous to clk_sys_i.
 */
// How it works
// - 16-bit counter, reload, programmable prescaler
// - timer, counter, trigger-start and gated modes
// - four independent capture/compare channels
// - divide by prescale+1, or trigger edges by prescale
// - new prescale loads on overflow or enable
// - reload value takes effect at once
// - single-shot bit picks single or continuous
// - count edges of cascade or external trigger
// - trigger edge starts counting
// - overflow inverts the toggle output pair
// - interrupt and DMA requests on events
// - quadrature encoder sets counting direction
// - single shot, encoder off: pulse, halt, clear run-enable
// - continuous: wrap to zero, set flag
// - mode field encodes the four modes
`timescale 1ns/1ps
`default_nettype none

module gtt_timebase
	import gtt_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Control
	input wire gtt_ctrl_s ctrl_i,
	input wire logic run_set_i,
	input wire logic run_clear_i,
	input wire logic [15:0] prescale_value_i,
	input wire logic [15:0] reload_value_i,
	// Trigger and channel inputs
	input wire logic internal_cascade_trigger_i,
	input wire logic external_trigger_input_i,
	input wire logic [GTT_NCH-1:0] ch_pin_i,
	input wire gtt_chan_cfg_s [GTT_NCH-1:0] ch_cfg_i,
	// Event enables
	input wire logic irq_ov_en_i,
	input wire logic irq_trig_en_i,
	input wire logic [GTT_NCH-1:0] irq_cc_en_i,
	input wire logic dma_ov_en_i,
	input wire logic dma_trig_en_i,
	// Flag clears
	input wire logic ov_clear_i,
	input wire logic trig_clear_i,
	input wire logic [GTT_NCH-1:0] cc_clear_i,
	// Status
	output logic run_o,
	output logic [15:0] count_value_o,
	output logic reload_overflow_o,
	output logic underflow_o,
	output logic dir_down_o,
	output logic ov_flag_o,
	output logic trig_flag_o,
	output logic [GTT_NCH-1:0] cc_flag_o,
	// Requests
	output logic irq_o,
	output logic dma_ov_o,
	output logic dma_trig_o,
	// Pins
	output logic tog_p_o,
	output logic tog_n_o,
	output logic [GTT_NCH-1:0] ch_out_o,
	output logic [GTT_NCH-1:0][15:0] ch_capture_o
);
	// ************************************************************
	// Declarations
	// ************************************************************
	gtt_state_e state_q;                   // Run state
	logic [15:0] psc_act_q;                // Prescale value in use
	logic [15:0] div_q;                    // Prescaler count
	logic [15:0] cnt_q;                    // Counter
	logic trig_prev_q;                     // Trigger source history
	logic enc_a_prev_q;                    // Encoder phase A history
	logic trig_lvl;                        // Selected trigger after polarity
	logic trig_edge;                       // Active trigger edge
	logic gate_on;                         // Gate level active
	logic run_rise;                        // Run-enable going 0 to 1
	logic pre_en;                          // Prescaler input event
	logic tick;                            // Divided count clock enable
	logic enc_edge;                        // Encoder phase A edge
	logic enc_down;                        // Encoder direction down
	logic ov_hit;                          // Reload overflow this cycle
	logic ud_hit;                          // Encoder underflow this cycle
	logic trig_hit;                        // Trigger start this cycle
	logic [GTT_NCH-1:0] ch_evt;            // Channel events

	assign count_value_o = cnt_q;

	// ************************************************************
	// Trigger, gate and encoder inputs
	// ************************************************************
	// pick cascade or external source
	assign trig_lvl = ctrl_i.trs_sel ? internal_cascade_trigger_i
		: (external_trigger_input_i ^ ctrl_i.etr_pol);
	assign trig_edge = trig_lvl & ~trig_prev_q;
	assign gate_on = external_trigger_input_i ^ ctrl_i.etr_pol;
	assign enc_edge = ch_pin_i[0] ^ enc_a_prev_q;
	assign enc_down = ~(ch_pin_i[0] ^ ch_pin_i[1]);
	assign run_rise = run_set_i & (state_q == GTT_ST_STOP);

	// Edge detector history, tracks the live level through reset so an inverted idle line gives no false edge
	always_ff @(posedge clk_sys_i) begin
		trig_prev_q <= trig_lvl;
		enc_a_prev_q <= ch_pin_i[0];
	end

	// ************************************************************
	// Run control
	// ************************************************************
	// trigger-start mode arms first, others run at once
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_q <= GTT_ST_STOP;
		end else begin
			case (state_q)
				GTT_ST_STOP: begin
					// mode 10 waits for the trigger
					if (run_set_i) begin
						state_q <= (ctrl_i.mode == GTT_MODE_TRIG) ? GTT_ST_ARMED : GTT_ST_RUN;
					end
				end
				GTT_ST_ARMED: begin
					if (run_clear_i) begin
						state_q <= GTT_ST_STOP;
					end else if (trig_edge) begin
						state_q <= GTT_ST_RUN;
					end
				end
				GTT_ST_RUN: begin
					if (run_clear_i || (ov_hit && ctrl_i.single_shot && !ctrl_i.enc_en)) begin
						state_q <= GTT_ST_STOP;
					end
				end
				default: begin
					state_q <= GTT_ST_STOP;
				end
			endcase
		end
	end

	assign trig_hit = (state_q == GTT_ST_ARMED) & trig_edge & ~run_clear_i;

	// Run-enable output in a flop of its own, high exactly while the state is not STOP
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			run_o <= 1'b0;
		end else begin
			run_o <= run_rise | (run_o & ~run_clear_i & ~(ov_hit & ctrl_i.single_shot & ~ctrl_i.enc_en));
		end
	end

	// ************************************************************
	// Prescaler
	// ************************************************************
	// mode 01 counts trigger edges, 11 gates the clock
	always_comb begin
		case (ctrl_i.mode)
			GTT_MODE_COUNT: pre_en = trig_edge;
			GTT_MODE_GATE: pre_en = gate_on;
			default: pre_en = 1'b1;
		endcase
	end

	// clock source ends at prescale, trigger source one earlier
	always_comb begin
		if (state_q != GTT_ST_RUN) begin
			tick = 1'b0;
		end else if (ctrl_i.enc_en) begin
			tick = enc_edge;
		end else if (ctrl_i.mode == GTT_MODE_COUNT) begin
			tick = pre_en & ((div_q + GTT_ONE) >= psc_act_q);
		end else begin
			tick = pre_en & (div_q == psc_act_q);
		end
	end

	// active prescale loads only on overflow or run start
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			psc_act_q <= GTT_PSC_RST;
		end else if (run_rise || ov_hit) begin
			psc_act_q <= prescale_value_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			div_q <= GTT_CNT_RST;
		end else if (run_rise || tick) begin
			div_q <= GTT_CNT_RST;
		end else if ((state_q == GTT_ST_RUN) && pre_en) begin
			div_q <= div_q + GTT_ONE;
		end
	end

	// ************************************************************
	// Counter
	// ************************************************************
	// compare against the live reload input
	// equality only, count assumed below reload
	assign ov_hit = tick & ~(ctrl_i.enc_en & enc_down) & (cnt_q == reload_value_i);
	assign ud_hit = tick & ctrl_i.enc_en & enc_down & (cnt_q == GTT_CNT_RST);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_q <= GTT_CNT_RST;
		end else if (tick) begin
			if (ud_hit) begin
				cnt_q <= GTT_CNT_MAX;
			end else if (ctrl_i.enc_en && enc_down) begin
				cnt_q <= cnt_q - GTT_ONE;
			end else if (ov_hit) begin
				cnt_q <= ctrl_i.single_shot && !ctrl_i.enc_en ? cnt_q : GTT_CNT_RST;
			end else begin
				cnt_q <= cnt_q + GTT_ONE;
			end
		end
	end

	// Event pulses and direction
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			reload_overflow_o <= 1'b0;
			underflow_o <= 1'b0;
			dir_down_o <= 1'b0;
		end else begin
			reload_overflow_o <= ov_hit;
			underflow_o <= ud_hit;
			if (tick && ctrl_i.enc_en) begin
				dir_down_o <= enc_down;
			end
		end
	end

	// ************************************************************
	// Flags and requests
	// ************************************************************
	// sticky flags, a new event wins over a clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ov_flag_o <= 1'b0;
			trig_flag_o <= 1'b0;
		end else begin
			ov_flag_o <= ov_hit | (ov_flag_o & ~ov_clear_i);
			trig_flag_o <= trig_hit | (trig_flag_o & ~trig_clear_i);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			dma_ov_o <= 1'b0;
			dma_trig_o <= 1'b0;
		end else begin
			irq_o <= (ov_flag_o & irq_ov_en_i) | (trig_flag_o & irq_trig_en_i) | (|(cc_flag_o & irq_cc_en_i));
			dma_ov_o <= ov_hit & dma_ov_en_i;
			dma_trig_o <= trig_hit & dma_trig_en_i;
		end
	end

	// ************************************************************
	// Toggle pair
	// ************************************************************
	// opposite levels, swapped on every overflow
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !ctrl_i.toggle_en) begin
			tog_p_o <= 1'b0;
			tog_n_o <= 1'b0;
		end else if (tog_p_o == tog_n_o) begin
			tog_p_o <= 1'b1;
			tog_n_o <= 1'b0;
		end else if (ov_hit) begin
			tog_p_o <= ~tog_p_o;
			tog_n_o <= ~tog_n_o;
		end
	end

	// ************************************************************
	// Capture/compare channels
	// ************************************************************
	// one channel per generate step
	for (genvar g = 0; g < GTT_NCH; g++) begin : g_ch
		gtt_chan u_chan (
			.clk_sys_i(clk_sys_i),
			.rst_i(rst_i),
			.cfg_i(ch_cfg_i[g]),
			.pin_i(ch_pin_i[g]),
			.count_i(cnt_q),
			.tick_i(tick),
			.capture_o(ch_capture_o[g]),
			.out_o(ch_out_o[g]),
			.event_o(ch_evt[g])
		);

		always_ff @(posedge clk_sys_i) begin
			if (rst_i) begin
				cc_flag_o[g] <= 1'b0;
			end else begin
				cc_flag_o[g] <= ch_evt[g] | (cc_flag_o[g] & ~cc_clear_i[g]);
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	single_halt_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ov_hit && ctrl_i.single_shot && !ctrl_i.enc_en |=> !run_o && reload_overflow_o && $stable(cnt_q))
		else $error("single shot did not halt");
	cont_wrap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ov_hit && !ctrl_i.single_shot && !ctrl_i.enc_en |=> cnt_q == 16'h0000 && ov_flag_o)
		else $error("continuous wrap wrong");
	stop_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state_q == GTT_ST_STOP && !run_rise |=> $stable(cnt_q) && $stable(div_q) && !reload_overflow_o)
		else $error("stopped timer moved");
	psc_keep_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!run_rise && !ov_hit |=> $stable(psc_act_q))
		else $error("prescale changed early");
	clk_div_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		tick && !ctrl_i.enc_en && ctrl_i.mode != GTT_MODE_COUNT |-> div_q == psc_act_q)
		else $error("clock divide wrong");
	trig_div_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		tick && !ctrl_i.enc_en && ctrl_i.mode == GTT_MODE_COUNT |-> trig_edge)
		else $error("count without trigger edge");
	trig_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		trig_hit |=> state_q == GTT_ST_RUN && trig_flag_o)
		else $error("trigger did not start");
	armed_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state_q == GTT_ST_ARMED |=> $stable(cnt_q))
		else $error("armed timer counted");
	tog_flip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ov_hit && ctrl_i.toggle_en && tog_p_o != tog_n_o ##1 ctrl_i.toggle_en
		|-> tog_p_o != $past(tog_p_o) && tog_n_o == !tog_p_o)
		else $error("toggle pair did not flip");
	flag_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ov_hit ##1 !ov_clear_i |=> ov_flag_o)
		else $error("overflow flag lost");
	reload_live_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		tick && !ctrl_i.enc_en && cnt_q == reload_value_i |=> reload_overflow_o)
		else $error("reload not used at once");

	single_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		ov_hit && ctrl_i.single_shot ##1 !run_o);
	wrap_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		ov_hit && !ctrl_i.single_shot ##[1:50] ov_hit);
	trig_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) trig_hit ##[1:20] tick);
	enc_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) ud_hit);
endmodule

`default_nettype wire

/* File: gtt_trig_src.sv */
/*
 * Trigger source model: drives the internal cascade line and the external
 * trigger line that stand at the far side of the time-base.
 * Assumes the bench clock; both lines change only at its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module gtt_trig_src (
	// Clock
	input wire logic clk_sys_i,
	// Trigger lines
	output logic casc_o,
	output logic ext_o
);
	// ************************************************************
	// Idle levels and stimulus tasks
	// ************************************************************
	// Both lines idle low between pulse trains
	initial begin
		casc_o = 1'b0;
		ext_o = 1'b0;
	end

	// Pulse train; gap sets a prompt or a slow source
	task automatic pulse(input int n, input logic sel, input int gap);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_i);
			if (sel) casc_o = 1'b1;
			else ext_o = 1'b1;
			@(negedge clk_sys_i);
			casc_o = 1'b0;
			ext_o = 1'b0;
			repeat (gap) @(negedge clk_sys_i);
		end
	endtask

	// Steady level on the external line, used as a gate
	task automatic level(input logic v);
		@(negedge clk_sys_i);
		ext_o = v;
	endtask
endmodule

`default_nettype wire

/* File: gtt_timebase_tb.sv */
/*
 * Self-checking bench of the time-base: counting, reload, prescale timing,
 * single and continuous runs, trigger, gate, flags and toggle pair.
 * Assumes gtt_pkg and gtt_trig_src are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module gtt_timebase_tb;
	import gtt_pkg::*;
	// ************************************************************
	// Stimulus and observed signals
	// ************************************************************
	logic clk_sys_i, rst_i, run_set, run_clear, ov_clear, trig_clear;
	gtt_ctrl_s ctrl;
	logic [15:0] pre_val, rel_val, c;
	logic casc, ext, tp;
	logic [GTT_NCH-1:0] ch_pin;
	gtt_chan_cfg_s [GTT_NCH-1:0] ch_cfg;
	logic run, wrap, ov_flag, trig_flag, irq, dma_ov, dma_trig, tog_p, tog_n;
	logic [15:0] count;
	logic udf, dir_dn, dma_en;
	logic [GTT_NCH-1:0] cc_en, cc_clear, cc_flag, ch_out;
	logic [GTT_NCH-1:0][15:0] ch_cap;
	int err_count, tests_run;

	gtt_trig_src u_src (.clk_sys_i(clk_sys_i), .casc_o(casc), .ext_o(ext));

	gtt_timebase u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctrl_i(ctrl), .run_set_i(run_set),
		.run_clear_i(run_clear), .prescale_value_i(pre_val), .reload_value_i(rel_val),
		.internal_cascade_trigger_i(casc), .external_trigger_input_i(ext), .ch_pin_i(ch_pin),
		.ch_cfg_i(ch_cfg), .irq_ov_en_i(1'b1), .irq_trig_en_i(1'b1), .irq_cc_en_i(cc_en),
		.dma_ov_en_i(dma_en), .dma_trig_en_i(dma_en), .ov_clear_i(ov_clear), .trig_clear_i(trig_clear),
		.cc_clear_i(cc_clear), .run_o(run), .count_value_o(count), .reload_overflow_o(wrap),
		.underflow_o(udf), .dir_down_o(dir_dn), .ov_flag_o(ov_flag), .trig_flag_o(trig_flag),
		.cc_flag_o(cc_flag), .irq_o(irq), .dma_ov_o(dma_ov), .dma_trig_o(dma_trig), .tog_p_o(tog_p),
		.tog_n_o(tog_n), .ch_out_o(ch_out), .ch_capture_o(ch_cap));

	// ************************************************************
	// Compare, report and drive tasks
	// ************************************************************
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("counts: %0d compared, %0d wrong", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Waits n rising edges, then lets their updates settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	// Sets up a run and pulses run-enable
	task automatic start(input gtt_mode_e m, input logic sel, input logic ss, input logic [15:0] p,
		input logic [15:0] r);
		@(negedge clk_sys_i);
		// Fresh reset so every test counts from zero with the toggle pair at its default
		rst_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		rst_i = 1'b0;
		tp = 1'b1;
		ctrl = '{mode: m, trs_sel: sel, single_shot: ss, etr_pol: 1'b0, toggle_en: 1'b1, enc_en: 1'b0};
		pre_val = p;
		rel_val = r;
		ch_pin = 4'($urandom);
		run_set = 1'b1;
		@(negedge clk_sys_i);
		run_set = 1'b0;
	endtask

	task automatic stop;
		@(negedge clk_sys_i);
		run_clear = 1'b1;
		@(negedge clk_sys_i);
		run_clear = 1'b0;
	endtask

	// Timer mode run against an integer model of count, period and wrap
	task automatic run_timer(input logic ss, input int nwrap);
		int per, gap, seen, cyc;
		logic [15:0] cur, r, p, p2, r2;
		logic first;
		p = 16'($urandom_range(3, 0));
		p2 = ss ? p : 16'($urandom_range(3, 0));
		r = 16'($urandom_range(8, 3));
		r2 = r + 16'($urandom_range(4, 1));
		per = p + 1;
		start(GTT_MODE_TIMER, 1'b0, ss, p, r);
		chk1(run, 1'b1);
		chk16(count, 16'h0000);
		cur = 16'h0000;
		gap = 0;
		seen = 0;
		cyc = 0;
		first = 1'b1;
		while (seen < nwrap && cyc < 2000) begin
			tick(1);
			gap++;
			cyc++;
			if (wrap === 1'b1) begin
				seen++;
				tp = ~tp;
				chk1(ov_flag, 1'b1);
				chk1(dma_ov, 1'b1);
				chk1(run, ~ss);
				if (ss) chk16(count, r);
			end
			chk1(tog_p, tp);
			chk1(tog_n, ~tp);
			if (count !== cur) begin
				chk16(count, (cur == r) ? 16'h0000 : cur + GTT_ONE);
				if (!first) chk16(16'(gap), 16'(per));
				if (wrap === 1'b1) per = p2 + 1;
				first = 1'b0;
				cur = count;
				gap = 0;
				// new values mid-run, reload above the count
				if (cur == 16'h0001 && seen == 0 && !ss) begin
					@(negedge clk_sys_i);
					pre_val = p2;
					rel_val = r2;
					r = r2;
				end
			end
		end
		chk16(16'(seen), 16'(nwrap));
		$display("test timer single=%0d done", ss);
	endtask

	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		#200000;
		err_count++;
		final_report();
	end

	initial begin
		int n;
		err_count = 0;
		tests_run = 0;
		rst_i = 1'b1;
		run_set = 1'b0;
		run_clear = 1'b0;
		ov_clear = 1'b0;
		trig_clear = 1'b0;
		pre_val = 16'h0000;
		rel_val = 16'h0000;
		ch_pin = 4'h0;
		cc_en = 4'h0;
		cc_clear = 4'h0;
		dma_en = 1'b1;
		ctrl = '{mode: GTT_MODE_TIMER, trs_sel: 1'b0, single_shot: 1'b0, etr_pol: 1'b0, toggle_en: 1'b1,
			enc_en: 1'b0};
		ch_cfg = '0;
		tp = 1'b1;
		void'($urandom(73));
		for (int i = 0; i < GTT_NCH; i++) ch_cfg[i].cmp = 16'($urandom_range(15, 0));
		ch_cfg[2].capture = 1'b1;
		repeat (20) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		tick(1);
		chk16(count, 16'h0000);
		chk1(run, 1'b0);
		chk1(tog_p, 1'b1);
		$display("test reset done");
		// continuous run, then stop and hold
		run_timer(1'b0, 3);
		stop();
		tick(1);
		c = count;
		for (int i = 0; i < 20; i++) begin
			tick(1);
			chk1(wrap, 1'b0);
		end
		chk16(count, c);
		chk1(irq, 1'b1);
		@(negedge clk_sys_i);
		ov_clear = 1'b1;
		@(negedge clk_sys_i);
		ov_clear = 1'b0;
		tick(2);
		chk1(ov_flag, 1'b0);
		chk1(irq, 1'b0);
		$display("test hold and clear done");
		run_timer(1'b1, 1);
		tick(5);
		chk1(run, 1'b0);
		// trigger edge counting, both sources, two divide ratios
		for (int s = 0; s < 2; s++) begin
			for (int k = 1; k < 3; k++) begin
				start(GTT_MODE_COUNT, s[0], 1'b0, 16'(k), 16'h00FF);
				u_src.pulse(7, s[0], $urandom_range(3, 1));
				tick(4);
				chk16(count, 16'(7 / k));
				stop();
			end
		end
		$display("test edge count done");
		// armed until a cascade edge arrives
		start(GTT_MODE_TRIG, 1'b1, 1'b0, 16'h0000, 16'h00FF);
		tick(8);
		chk16(count, 16'h0000);
		fork
			u_src.pulse(1, 1'b1, 0);
		join_none
		n = 0;
		while (trig_flag !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		chk1(trig_flag, 1'b1);
		chk1(dma_trig, 1'b1);
		tick(5);
		chk1(count !== 16'h0000, 1'b1);
		@(negedge clk_sys_i);
		trig_clear = 1'b1;
		@(negedge clk_sys_i);
		trig_clear = 1'b0;
		tick(2);
		chk1(trig_flag, 1'b0);
		// Capture on channel 2 latches the count seen at the rising edge
		@(negedge clk_sys_i);
		ch_pin[2] = 1'b0;
		@(negedge clk_sys_i);
		ch_pin[2] = 1'b1;
		c = count;
		tick(1);
		chk16(ch_cap[2], c);
		tick(1);
		chk1(cc_flag[2], 1'b1);
		@(negedge clk_sys_i);
		cc_clear = 4'h4;
		@(negedge clk_sys_i);
		cc_clear = 4'h0;
		tick(1);
		chk1(cc_flag[2], 1'b0);
		stop();
		$display("test trigger start done");
		// gated timing follows the external level
		start(GTT_MODE_GATE, 1'b0, 1'b0, 16'h0000, 16'h00FF);
		tick(10);
		chk16(count, 16'h0000);
		u_src.level(1'b1);
		tick(6);
		chk1(count !== 16'h0000, 1'b1);
		u_src.level(1'b0);
		tick(2);
		c = count;
		tick(8);
		chk16(count, c);
		chk1(ch_out[1], c < ch_cfg[1].cmp);
		stop();
		$display("test gate done");
		// encoder steps down through zero, then back up
		start(GTT_MODE_COUNT, 1'b0, 1'b1, 16'h0001, 16'h00FF);
		ch_pin = 4'h2;
		tick(1);
		@(negedge clk_sys_i);
		ctrl.enc_en = 1'b1;
		ch_pin = 4'h3;
		tick(1);
		chk16(count, GTT_CNT_MAX);
		chk1(udf, 1'b1);
		chk1(dir_dn, 1'b1);
		@(negedge clk_sys_i);
		ch_pin = 4'h2;
		tick(1);
		chk16(count, 16'h0000);
		chk1(dir_dn, 1'b0);
		stop();
		$display("test encoder done");
		final_report();
	end
endmodule

`default_nettype wire
